// ==== verilog/nfs_pkg.sv ====
package nfs_pkg;

    localparam int NUM_NOTCH = 4;
    localparam int DATA_W = 16;
    localparam int FREQ_W = 13;
    localparam int WID_W = 5;
    localparam int DEP_W = 7;

    localparam logic [FREQ_W-1:0] FREQ_MIN = 13'h0032;
    localparam logic [FREQ_W-1:0] FREQ_MAX = 13'h1388;
    localparam logic [WID_W-1:0] WID_MAX = 5'h14;
    localparam logic [WID_W-1:0] WID_DEF = 5'h02;
    localparam logic [DEP_W-1:0] DEP_MAX = 7'h63;
    localparam logic [DEP_W-1:0] DEP_DEF = 7'h00;

    // Number of adaptive filters enabled
    localparam logic [1:0] ADAPT_ONE = 2'h1;
    localparam logic [1:0] ADAPT_TWO = 2'h2;

    // Index of the notches fed by the adaptive filter
    localparam int ADAPT_IDX1 = 2;
    localparam int ADAPT_IDX2 = 3;

    // Fixed point scaling of the stage arithmetic
    localparam int FRAC = 14;
    localparam int K_SHIFT = 10;
    localparam real TWO_PI = 6.283185307;
    localparam real K_SCALE = 16777216.0;
    localparam int Q_BASE = 32'h0000_0002;
    localparam int Q_STEP = 32'h0000_0333;
    localparam int DEP_SPAN = 32'h0000_0064;
    localparam int G_STEP = 32'h0000_00A3;
    localparam int FS_DEF_HZ = 40000;
    localparam int FS_MIN_HZ = 20000;

    typedef struct packed {
        logic [FREQ_W-1:0] frequency;
        logic [WID_W-1:0] width;
        logic [DEP_W-1:0] depth;
    } nfs_cfg_t;

    localparam nfs_cfg_t NFS_CFG_DEF = '{frequency: FREQ_MAX, width: WID_DEF, depth: DEP_DEF};

    function automatic logic [FREQ_W-1:0] nfs_clamp_freq(input logic [FREQ_W-1:0] f);
        if (f < FREQ_MIN) begin
            return FREQ_MIN;
        end else if (f > FREQ_MAX) begin
            return FREQ_MAX;
        end
        return f;
    endfunction

    function automatic nfs_cfg_t nfs_clamp_cfg(input nfs_cfg_t c);
        nfs_cfg_t r;
        r.frequency = nfs_clamp_freq(c.frequency);
        r.width = (c.width > WID_MAX) ? WID_MAX : c.width;
        r.depth = (c.depth > DEP_MAX) ? DEP_MAX : c.depth;
        return r;
    endfunction

endpackage

// ==== verilog/nfs_stage.sv ====
`timescale 1ns/1ps
module nfs_stage #(
    parameter int FS_HZ = nfs_pkg::FS_DEF_HZ
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    input wire logic signed [nfs_pkg::DATA_W-1:0] in_data,
    input wire nfs_pkg::nfs_cfg_t cfg,
    output logic out_valid,
    output logic signed [nfs_pkg::DATA_W-1:0] out_data
);
    import nfs_pkg::*;

    localparam int FREQ_K = int'(TWO_PI * K_SCALE / real'(FS_HZ));

    if (FS_HZ < FS_MIN_HZ) begin : g_fs_check
        $error("Sample rate too low for the notch range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // State variable notch arithmetic

    logic signed [39:0] lp_q, bp_q, lp_d, bp_d;
    logic signed [39:0] in_x, f_c, q_c, g_c, qbp, hp, notch_v;
    logic bypass;

    function automatic logic signed [DATA_W-1:0] sat(input logic signed [39:0] x);
        logic signed [39:0] hi;
        logic signed [39:0] lo;
        hi = 40'sd1 <<< (DATA_W - 1);
        lo = -hi;
        hi = hi - 40'sd1;
        if (x > hi) begin
            return hi[DATA_W-1:0];
        end else if (x < lo) begin
            return lo[DATA_W-1:0];
        end
        return x[DATA_W-1:0];
    endfunction

    always_comb begin
        bypass = (cfg.frequency == FREQ_MAX);
        in_x = {{(40 - DATA_W){in_data[DATA_W-1]}}, in_data};
        f_c = (40'(cfg.frequency) * 40'(FREQ_K)) >>> K_SHIFT;
        q_c = (40'(cfg.width) + 40'(Q_BASE)) * 40'(Q_STEP);
        g_c = (40'(DEP_SPAN) - 40'(cfg.depth)) * 40'(G_STEP);
        qbp = (q_c * bp_q) >>> FRAC;
        // Low pass moves first so the zeros sit on the unit circle
        lp_d = lp_q + ((f_c * bp_q) >>> FRAC);
        hp = in_x - lp_d - qbp;
        bp_d = bp_q + ((f_c * hp) >>> FRAC);
        notch_v = in_x - ((g_c * qbp) >>> FRAC);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Filter state

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lp_q <= '0;
            bp_q <= '0;
        end else if (in_valid) begin
            if (bypass) begin
                lp_q <= '0;
                bp_q <= '0;
            end else begin
                lp_q <= lp_d;
                bp_q <= bp_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output register

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                out_data <= bypass ? in_data : sat(notch_v);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_bypass_pass: assert property (@(posedge clk) disable iff (!rst_b)
        in_valid && cfg.frequency == FREQ_MAX |=> out_data == $past(in_data))
        else $error("Disabled notch did not pass the sample");

endmodule

// ==== verilog/nfs_top.sv ====
`timescale 1ns/1ps
module nfs_top #(
    parameter int FS_HZ = nfs_pkg::FS_DEF_HZ
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire nfs_pkg::nfs_cfg_t cfg_wdata [nfs_pkg::NUM_NOTCH],
    input wire logic [nfs_pkg::NUM_NOTCH-1:0] cfg_wr,
    input wire logic [1:0] adapt_filters,
    input wire logic adapt_res1_valid,
    input wire logic [nfs_pkg::FREQ_W-1:0] adapt_res1_freq,
    input wire logic adapt_res2_valid,
    input wire logic [nfs_pkg::FREQ_W-1:0] adapt_res2_freq,
    input wire logic sample_valid,
    input wire logic signed [nfs_pkg::DATA_W-1:0] sample_in,
    output logic sample_out_valid,
    output logic signed [nfs_pkg::DATA_W-1:0] sample_out,
    output nfs_pkg::nfs_cfg_t cfg_active [nfs_pkg::NUM_NOTCH],
    output logic [nfs_pkg::NUM_NOTCH-1:0] notch_enabled
);
    import nfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Adaptive overwrite decode

    logic [NUM_NOTCH-1:0] adapt_hit;
    logic [FREQ_W-1:0] adapt_freq [NUM_NOTCH];

    always_comb begin
        adapt_hit = '0;
        for (int i = 0; i < NUM_NOTCH; i++) begin
            adapt_freq[i] = FREQ_MAX;
        end
        adapt_hit[ADAPT_IDX1] = adapt_res1_valid
            && (adapt_filters == ADAPT_ONE || adapt_filters == ADAPT_TWO);
        adapt_freq[ADAPT_IDX1] = adapt_res1_freq;
        adapt_hit[ADAPT_IDX2] = adapt_res2_valid && adapt_filters == ADAPT_TWO;
        adapt_freq[ADAPT_IDX2] = adapt_res2_freq;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Settings bank

    logic signed [DATA_W-1:0] chain_data [NUM_NOTCH+1];
    logic [NUM_NOTCH:0] chain_valid;

    assign chain_data[0] = sample_in;
    assign chain_valid[0] = sample_valid;

    for (genvar i = 0; i < NUM_NOTCH; i++) begin : g_notch
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                cfg_active[i] <= NFS_CFG_DEF;
            end else begin
                if (cfg_wr[i]) begin
                    cfg_active[i] <= nfs_clamp_cfg(cfg_wdata[i]);
                end
                // Adaptive frequency wins over a software write in the same cycle; width and depth keep the written values
                if (adapt_hit[i]) begin
                    cfg_active[i].frequency <= nfs_clamp_freq(adapt_freq[i]);
                end
            end
        end

        assign notch_enabled[i] = cfg_active[i].frequency != FREQ_MAX;

        nfs_stage #(
            .FS_HZ(FS_HZ)
        ) u_stage (
            .clk(clk),
            .rst_b(rst_b),
            .in_valid(chain_valid[i]),
            .in_data(chain_data[i]),
            .cfg(cfg_active[i]),
            .out_valid(chain_valid[i+1]),
            .out_data(chain_data[i+1])
        );
    end

    assign sample_out = chain_data[NUM_NOTCH];
    assign sample_out_valid = chain_valid[NUM_NOTCH];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_freq_range: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_active[0].frequency >= FREQ_MIN && cfg_active[3].frequency <= FREQ_MAX
        && cfg_active[2].frequency >= FREQ_MIN)
        else $error("Notch frequency out of range");

    a_width_clamp: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_wr[1] && cfg_wdata[1].width > WID_MAX |=> cfg_active[1].width == WID_MAX)
        else $error("Width not clamped");

    a_depth_clamp: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_wr[0] && cfg_wdata[0].depth > DEP_MAX |=> cfg_active[0].depth == DEP_MAX)
        else $error("Depth not clamped");

    a_wr_load: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_wr[0] |=> cfg_active[0] == nfs_clamp_cfg($past(cfg_wdata[0])))
        else $error("First notch did not take its written setting");

    a_res1_load: assert property (@(posedge clk) disable iff (!rst_b)
        adapt_res1_valid && adapt_filters == ADAPT_ONE
        |=> cfg_active[2].frequency == nfs_clamp_freq($past(adapt_res1_freq)))
        else $error("Third notch did not take first resonance");

    a_res1_two: assert property (@(posedge clk) disable iff (!rst_b)
        adapt_res1_valid && adapt_filters == ADAPT_TWO
        |=> cfg_active[2].frequency == nfs_clamp_freq($past(adapt_res1_freq)))
        else $error("Third notch did not take first resonance with two filters");

    a_res2_load: assert property (@(posedge clk) disable iff (!rst_b)
        adapt_res2_valid && adapt_filters == ADAPT_TWO
        |=> cfg_active[3].frequency == nfs_clamp_freq($past(adapt_res2_freq)))
        else $error("Fourth notch did not take second resonance");

    a_res2_ignored: assert property (@(posedge clk) disable iff (!rst_b)
        adapt_res2_valid && adapt_filters == ADAPT_ONE && !cfg_wr[3]
        |=> $stable(cfg_active[3].frequency))
        else $error("Fourth notch changed with one adaptive filter");

    a_mode_off: assert property (@(posedge clk) disable iff (!rst_b)
        adapt_filters != ADAPT_ONE && adapt_filters != ADAPT_TWO && !cfg_wr[2]
        |=> $stable(cfg_active[2].frequency))
        else $error("Third notch changed with adaptive filters off");

    a_merge_width: assert property (@(posedge clk) disable iff (!rst_b)
        cfg_wr[2] && adapt_hit[2]
        |=> cfg_active[2].width == (($past(cfg_wdata[2].width) > WID_MAX) ? WID_MAX
        : $past(cfg_wdata[2].width)))
        else $error("Software width lost when adaptive load met a write");

    a_chain_latency: assert property (@(posedge clk) disable iff (!rst_b)
        sample_valid |-> ##4 sample_out_valid)
        else $error("Sample did not leave the cascade after four cycles");

    a_all_bypass: assert property (@(posedge clk) disable iff (!rst_b)
        sample_valid && notch_enabled == '0 ##1 notch_enabled == '0 [*3]
        |=> sample_out == $past(sample_in, 4))
        else $error("Disabled cascade altered the sample");

    c_merge_write: cover property (@(posedge clk) disable iff (!rst_b)
        cfg_wr[2] && adapt_hit[2]);

    c_res1_load: cover property (@(posedge clk) disable iff (!rst_b)
        adapt_res1_valid && adapt_filters == ADAPT_TWO);
    c_res2_load: cover property (@(posedge clk) disable iff (!rst_b)
        adapt_res2_valid && adapt_filters == ADAPT_TWO);
    c_active_out: cover property (@(posedge clk) disable iff (!rst_b)
        sample_out_valid && notch_enabled == 4'hF);

endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import nfs_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    nfs_cfg_t cfg_wdata [NUM_NOTCH];
    logic [NUM_NOTCH-1:0] cfg_wr = '0;
    logic [1:0] adapt_filters = 2'h0;
    logic adapt_res1_valid = 1'b0;
    logic [FREQ_W-1:0] adapt_res1_freq = '0;
    logic adapt_res2_valid = 1'b0;
    logic [FREQ_W-1:0] adapt_res2_freq = '0;
    logic sample_valid = 1'b0;
    logic signed [DATA_W-1:0] sample_in = '0;
    logic sample_out_valid;
    logic signed [DATA_W-1:0] sample_out;
    nfs_cfg_t cfg_active [NUM_NOTCH];
    logic [NUM_NOTCH-1:0] notch_enabled;
    int error_cnt = 0;
    int checks_done = 0;
    int seed = 32'hbeecb7d6;
    int peak = 0;
    int mag;
    int p0;
    logic measure = 1'b0;
    logic signed [DATA_W-1:0] exp_q [$];
    logic signed [DATA_W-1:0] v;

    nfs_top i_dut (.clk(clk), .rst_b(rst_b), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr),
        .adapt_filters(adapt_filters), .adapt_res1_valid(adapt_res1_valid),
        .adapt_res1_freq(adapt_res1_freq), .adapt_res2_valid(adapt_res2_valid),
        .adapt_res2_freq(adapt_res2_freq), .sample_valid(sample_valid), .sample_in(sample_in),
        .sample_out_valid(sample_out_valid), .sample_out(sample_out),
        .cfg_active(cfg_active), .notch_enabled(notch_enabled));

    initial begin
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic fail(input string m);
        error_cnt++;
        $display("mismatch at %0t: %s", $time, m);
    endtask

    function automatic nfs_cfg_t mk(input logic [12:0] f, input logic [4:0] w, input logic [6:0] d);
        return '{frequency: f, width: w, depth: d};
    endfunction

    task automatic chk(input int i, input nfs_cfg_t e);
        checks_done++;
        if (cfg_active[i] !== e || notch_enabled[i] !== (e.frequency != FREQ_MAX)) begin
            fail($sformatf("notch %0d setting", i));
        end
    endtask

    task automatic wr(input int i, input nfs_cfg_t c);
        @(posedge clk);
        cfg_wdata[i] <= c;
        cfg_wr[i] <= 1'b1;
        @(posedge clk);
        cfg_wr[i] <= 1'b0;
        #1;
    endtask

    task automatic adapt(input logic [1:0] m, input logic [12:0] f1, input logic [12:0] f2);
        @(posedge clk);
        adapt_filters <= m;
        adapt_res1_valid <= 1'b1;
        adapt_res1_freq <= f1;
        adapt_res2_valid <= 1'b1;
        adapt_res2_freq <= f2;
        @(posedge clk);
        adapt_res1_valid <= 1'b0;
        adapt_res2_valid <= 1'b0;
        #1;
    endtask

    task automatic sine(input logic [6:0] d, output int pk);
        wr(0, mk(13'h03e8, WID_DEF, d));
        for (int k = 0; k < 400; k++) begin
            @(posedge clk);
            sample_valid <= 1'b1;
            sample_in <= DATA_W'($rtoi(8000.0 * $sin(TWO_PI * k / 40.0)));
            measure <= (k > 200);
        end
        @(posedge clk);
        sample_valid <= 1'b0;
        repeat (6) @(posedge clk);
        measure <= 1'b0;
        pk = peak;
        peak = 0;
    endtask
    ////////////////////////////////////////////////////////////////
    // Output watcher
    always @(posedge clk) begin
        if (sample_out_valid === 1'b1) begin
            mag = (sample_out < 0) ? -int'(sample_out) : int'(sample_out);
            if (exp_q.size() > 0) begin
                checks_done++;
                if (sample_out !== exp_q.pop_front()) fail("bypass sample");
            end else if (measure && mag > peak) begin
                peak = mag;
            end
        end
    end

    initial begin
        repeat (50000) @(posedge clk);
        fail("timeout");
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        foreach (cfg_wdata[i]) cfg_wdata[i] = NFS_CFG_DEF;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        for (int i = 0; i < NUM_NOTCH; i++) chk(i, mk(13'h1388, 5'h02, 7'h00));
        // Random samples back to back through four disabled notches
        for (int k = 0; k < 24; k++) begin
            @(posedge clk);
            v = DATA_W'($random(seed));
            sample_valid <= 1'b1;
            sample_in <= v;
            exp_q.push_back(v);
        end
        @(posedge clk);
        sample_valid <= 1'b0;
        repeat (8) @(posedge clk);
        // Boundary values of every field on every notch
        for (int i = 0; i < NUM_NOTCH; i++) begin
            wr(i, mk(13'h0031, 5'h15, 7'h64));
            chk(i, mk(FREQ_MIN, WID_MAX, DEP_MAX));
            wr(i, mk(13'h1389, 5'h00, 7'h00));
            chk(i, mk(FREQ_MAX, 5'h00, 7'h00));
        end
        // Adaptive resonance loads under each mode
        adapt(ADAPT_ONE, 13'h0190, 13'h0320);
        chk(2, mk(13'h0190, 5'h00, 7'h00));
        chk(3, mk(FREQ_MAX, 5'h00, 7'h00));
        adapt(ADAPT_TWO, 13'h01f4, 13'h0010);
        chk(2, mk(13'h01f4, 5'h00, 7'h00));
        chk(3, mk(FREQ_MIN, 5'h00, 7'h00));
        adapt(2'h0, 13'h0064, 13'h0064);
        adapt(2'h3, 13'h0064, 13'h0064);
        chk(2, mk(13'h01f4, 5'h00, 7'h00));
        chk(3, mk(FREQ_MIN, 5'h00, 7'h00));
        // Software write and adaptive load meet in one cycle
        fork
            wr(2, mk(13'h0258, 5'h05, 7'h0a));
            adapt(ADAPT_TWO, 13'h02bc, 13'h1770);
        join
        chk(2, mk(13'h02bc, 5'h05, 7'h0a));
        chk(3, mk(FREQ_MAX, 5'h00, 7'h00));
        wr(2, NFS_CFG_DEF);
        wr(3, NFS_CFG_DEF);
        // Tone at the centre frequency, deep and shallow notch
        sine(7'h00, p0);
        checks_done++;
        if (p0 >= 4000) fail("tone not attenuated");
        sine(7'h63, peak);
        checks_done++;
        if (peak <= p0) fail("depth has no effect");
        report_and_stop();
    end
endmodule
